// file: hw/irq_arbiter_defs.svh
`ifndef IRQ_ARBITER_DEFS_SVH
`define IRQ_ARBITER_DEFS_SVH

// register byte offsets
`define OFS_ENABLE 8'h00
`define OFS_PRIO_LO 8'h04
`define OFS_PRIO_HI 8'h08
`define OFS_MASK 8'h0c
`define OFS_STATUS 8'h10
`define OFS_PENDING 8'h14
`define OFS_VEC_BASE 8'h18

// reset values
`define RST_ENABLE 16'h0000
`define RST_PRIO 64'h0000_0000_0000_0000
`define RST_VEC_BASE 8'h40
`define RST_MASK 3'h7

// field positions and the nmi level
`define MASK_LVL_LSB 0
`define MASK_TRACE_BIT 7
`define NMI_LEVEL 3'h7

`endif

// file: hw/irq_arbiter_pkg.sv
`default_nettype none
package irq_arbiter_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_ACK
    } arb_state_type;

    // CPU-facing acceptance request
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [2:0] level;
        logic [7:0] vector;
    } accept_req_type;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_type;
endpackage
`default_nettype wire

// file: hw/eight_level_interrupt_arbiter.sv
// How it works
// RL1: non-NMI requests masked over eight levels
// RL2: only enabled sources enter arbitration
// RL3: highest priority wins, others stay pending
// RL4: equal priority: lowest source index wins
// RL5: accept only priority strictly above mask
// RL6: CPU finishes current instruction before handling
// RL7: CPU stacks PC, condition and extended control
// RL8: simple mode omits extended control from stack
// RL9: CPU clears trace bit on acceptance
// RL10: CPU loads mask with accepted priority
// RL11: NMI acceptance sets mask to seven
// RL12: device supplies vector; CPU fetches handler
// RL13: pending held; rearbitrate on mask change
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`include "irq_arbiter_defs.svh"
`default_nettype none
module eight_level_interrupt_arbiter #(
    parameter int NSRC = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_clear,
    input wire logic nmi_event,
    input wire logic cpu_ack,
    input wire logic [2:0] cpu_mask_level,
    input wire logic cpu_mask_wr,
    output irq_arbiter_pkg::accept_req_type accept_q,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import irq_arbiter_pkg::*;

    logic [NSRC-1:0] irq_enable_reg_q;
    logic [NSRC*4-1:0] priority_level_regs_q;
    logic [7:0] extended_control_reg_q;
    logic [7:0] vec_base_q;
    logic [NSRC-1:0] pending_q;
    logic nmi_pend_q;
    arb_state_type state_q;
    logic [$clog2(NSRC)-1:0] taken_src_q;
    logic taken_nmi_q;

    // the top bit of each nibble is spare
    function automatic logic [2:0] prio_of(input logic [NSRC*4-1:0] p, input int i);
        prio_of = p[i*4 +: 3];
    endfunction

    // nmi owns the base entry, sources follow it in index order
    function automatic logic [7:0] vec_of(input logic [7:0] base, input logic nmi,
                                          input logic [$clog2(NSRC)-1:0] idx);
        if (nmi) begin
            vec_of = base;
        end else begin
            vec_of = base + 8'h01 + 8'(idx);
        end
    endfunction

    function automatic logic [31:0] status_word(input accept_req_type a);
        status_word = {16'h0000, a.vector, 3'h0, a.level, a.nmi, a.valid};
    endfunction

    // arbitration: combinational search over enabled pending sources
    logic win_valid;
    logic [2:0] win_level;
    logic [$clog2(NSRC)-1:0] win_idx;
    always_comb begin
        win_valid = 1'b0;
        win_level = 3'h0;
        win_idx = '0;
        for (int i = 0; i < NSRC; i++) begin
            // strict compare keeps the lowest index on ties
            if (pending_q[i] && irq_enable_reg_q[i] && // RL2
                (!win_valid || prio_of(priority_level_regs_q, i) > win_level)) begin // RL3 RL4
                win_valid = 1'b1;
                win_level = prio_of(priority_level_regs_q, i);
                win_idx = i[$clog2(NSRC)-1:0];
            end
        end
    end

    wire logic [2:0] mask_lvl = extended_control_reg_q[`MASK_LVL_LSB +: 3];
    // mask is read live each cycle; in ST_IDLE any change re-arbitrates at once, a standing offer is only withdrawn
    wire logic win_ok = win_valid && (win_level > mask_lvl); // RL1 RL5 RL13

    // an ack only counts while an offer stands
    // a stray ack from the cpu is ignored, never turned into a clear
    wire logic ack_take = cpu_ack && (state_q == ST_WAIT_ACK);

    // pending latches: set beats clear, so an event on an enabled source is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_q <= '0;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (src_event[i] && irq_enable_reg_q[i]) begin // RL2
                    pending_q[i] <= 1'b1; // RL13
                end else if (src_clear[i] || !irq_enable_reg_q[i] ||
                             (ack_take && !taken_nmi_q &&
                              taken_src_q == i[$clog2(NSRC)-1:0])) begin
                    pending_q[i] <= 1'b0; // RL13
                end
            end
        end
    end

    // nmi has no enable and no clear but its own acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_event) begin
            nmi_pend_q <= 1'b1;
        end else if (ack_take && taken_nmi_q) begin
            nmi_pend_q <= 1'b0;
        end
    end

    // acceptance handshake toward the CPU; it acks after finishing its instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            accept_q <= '0;
            taken_src_q <= '0;
            taken_nmi_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (nmi_pend_q) begin
                        accept_q.valid <= 1'b1;
                        accept_q.nmi <= 1'b1;
                        accept_q.level <= `NMI_LEVEL; // RL11
                        accept_q.vector <= vec_of(vec_base_q, 1'b1, '0); // RL12
                        taken_nmi_q <= 1'b1;
                        state_q <= ST_WAIT_ACK;
                    end else if (win_ok) begin // RL5
                        accept_q.valid <= 1'b1;
                        accept_q.nmi <= 1'b0;
                        accept_q.level <= win_level; // RL10
                        accept_q.vector <= vec_of(vec_base_q, 1'b0, win_idx); // RL12
                        taken_src_q <= win_idx;
                        taken_nmi_q <= 1'b0;
                        state_q <= ST_WAIT_ACK;
                    end
                end
                ST_WAIT_ACK: begin
                    // RL6 cpu_ack comes only at an instruction boundary
                    if (cpu_ack) begin
                        accept_q.valid <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (!taken_nmi_q && !win_ok) begin
                        // withdrawn: source cleared or mask raised
                        accept_q.valid <= 1'b0; // RL13
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // mirror of the CPU control word; stacking itself is the CPU's job (RL7 RL8)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            extended_control_reg_q <= {5'h00, `RST_MASK};
        end else if (ack_take) begin
            // trace is never set here; only the cpu itself sets it
            extended_control_reg_q[`MASK_TRACE_BIT] <= 1'b0; // RL9
            extended_control_reg_q[`MASK_LVL_LSB +: 3] <= accept_q.level; // RL10 RL11
        end else if (cpu_mask_wr) begin
            extended_control_reg_q[`MASK_LVL_LSB +: 3] <= cpu_mask_level; // RL13
        end
    end

    // axi4-lite write: address and data taken in either order
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    wire logic wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    // readies are flops so no combinational path runs back to the master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                // a bad address still completes, only with an error response
                unique case (aw_addr_q)
                    `OFS_ENABLE, `OFS_PRIO_LO, `OFS_PRIO_HI, `OFS_VEC_BASE: ;
                    `OFS_MASK, `OFS_STATUS, `OFS_PENDING: ;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
        end
    end

    // strobes ignored: every register is whole-word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_reg_q <= `RST_ENABLE;
        end else if (wr_fire && aw_addr_q == `OFS_ENABLE) begin
            irq_enable_reg_q <= w_data_q[NSRC-1:0]; // RL2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            priority_level_regs_q <= `RST_PRIO;
        end else if (wr_fire && aw_addr_q == `OFS_PRIO_LO) begin
            priority_level_regs_q[31:0] <= w_data_q;
        end else if (wr_fire && aw_addr_q == `OFS_PRIO_HI) begin
            priority_level_regs_q[63:32] <= w_data_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_base_q <= `RST_VEC_BASE;
        end else if (wr_fire && aw_addr_q == `OFS_VEC_BASE) begin
            vec_base_q <= w_data_q[7:0];
        end
    end

    // read channel: data loads on the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                `OFS_ENABLE: s_axi_rdata <= 32'(irq_enable_reg_q);
                `OFS_PRIO_LO: s_axi_rdata <= priority_level_regs_q[31:0];
                `OFS_PRIO_HI: s_axi_rdata <= priority_level_regs_q[63:32];
                `OFS_MASK: s_axi_rdata <= {24'h0, extended_control_reg_q};
                `OFS_STATUS: s_axi_rdata <= status_word(accept_q);
                `OFS_PENDING: s_axi_rdata <= {15'h0, nmi_pend_q, 16'(pending_q)};
                `OFS_VEC_BASE: s_axi_rdata <= {24'h0, vec_base_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end

    // one-cycle pulse, so one read address is never taken twice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
        end
    end
endmodule // eight_level_interrupt_arbiter
`default_nettype wire

// file: test/arb_chk_properties.sv
`default_nettype none
module arb_chk #(
    parameter int NSRC = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic nmi_event,
    input wire logic cpu_ack,
    input wire logic [2:0] cpu_mask_level,
    input wire logic cpu_mask_wr,
    input wire irq_arbiter_pkg::accept_req_type accept_q,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_arbiter_pkg::*;
    logic [2:0] mask_q;
    // mirror of the cpu mask, which the design keeps out of sight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= 3'h7;
        end else if (cpu_mask_wr) begin
            mask_q <= cpu_mask_level;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // the offer lags a mask write by one cycle
    chk_above_mask: assert property (accept_q.valid && !accept_q.nmi && !$past(cpu_mask_wr)
        |-> accept_q.level > mask_q) else $error("offer not above mask");
    chk_nmi_offer: assert property (nmi_event && !accept_q.valid
        |-> ##[1:3] (accept_q.valid && accept_q.nmi)) else $error("nmi not offered");
    chk_nmi_hold: assert property (accept_q.valid && accept_q.nmi && !cpu_ack
        |=> accept_q.nmi) else $error("nmi withdrawn");
    chk_ack_clears: assert property (cpu_ack |=> !accept_q.valid) else $error("offer after ack");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready && !s_axi_rvalid
        |=> s_axi_rvalid) else $error("no read answer");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10
        |-> s_axi_rdata == 32'h0) else $error("error data not zero");
    cov_nmi: cover property (accept_q.valid && accept_q.nmi);
    cov_ack: cover property (cpu_ack);
    cov_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // arb_chk
bind eight_level_interrupt_arbiter arb_chk #(.NSRC(NSRC)) arb_chk_inst (.*);
`default_nettype wire

// file: test/cpu_model.sv
`default_nettype none
module cpu_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire irq_arbiter_pkg::accept_req_type accept_q,
    input wire logic ack_en,
    input wire logic [3:0] wait_cyc,
    input wire logic set_mask,
    input wire logic [2:0] set_val,
    output logic cpu_ack,
    output logic [2:0] cpu_mask_level,
    output logic cpu_mask_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_arbiter_pkg::*;
    logic [3:0] cnt_q;
    // ack_en low stands for a long instruction still running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            cpu_ack <= 1'b0;
            cpu_mask_wr <= 1'b0;
            cpu_mask_level <= 3'h7;
        end else begin
            cpu_ack <= 1'b0;
            cpu_mask_wr <= set_mask;
            if (set_mask) cpu_mask_level <= set_val;
            if (accept_q.valid && ack_en && !cpu_ack) begin
                cnt_q <= cnt_q + 4'h1;
                // eight-level mode only: stack and vector fetch not modelled
                if (cnt_q == wait_cyc) begin
                    cnt_q <= 4'h0;
                    cpu_ack <= 1'b1;
                    cpu_mask_wr <= 1'b1;
                    cpu_mask_level <= accept_q.nmi ? 3'h7 : accept_q.level;
                end
            end else begin
                cnt_q <= 4'h0;
            end
        end
    end
endmodule // cpu_model
`default_nettype wire

// file: test/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_arbiter_pkg::*;
    logic aclk, aresetn, nmi_event, cpu_ack, cpu_mask_wr, ack_en, set_mask;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] src_event, src_clear;
    logic [2:0] cpu_mask_level, set_val;
    logic [3:0] wait_cyc, s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    accept_req_type accept_q;
    int error_cnt, total_checks;
    eight_level_interrupt_arbiter eight_level_interrupt_arbiter_inst (.*);
    cpu_model cpu_model_inst (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        check(32'(s_axi_bresp), 32'h0);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        check(s_axi_rdata, d);
        check(32'(s_axi_rresp), 32'(r));
    endtask
    // offers stand while the cpu model holds off, so a fixed wait is safe
    task automatic offer(input logic [7:0] v, input logic [2:0] l);
        repeat (3) @(posedge aclk);
        check(32'({accept_q.valid, accept_q.vector}), 32'({1'b1, v}));
        if (l != 3'h0) check(32'(accept_q.level), 32'(l));
    endtask
    task automatic ack();
        ack_en <= 1'b1;
        repeat (6) @(posedge aclk);
        ack_en <= 1'b0;
        check(32'(accept_q.valid), 32'h0);
    endtask
    task automatic mask(input logic [2:0] v);
        set_val <= v;
        set_mask <= 1'b1;
        @(posedge aclk);
        set_mask <= 1'b0;
    endtask
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        #20000;
        error_cnt++;
        results();
    end
    initial begin
        {aresetn, nmi_event, ack_en, set_mask, src_event, src_clear, set_val, s_axi_awvalid,
            s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        // both response readies stay high: the master always takes an answer at once
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        s_axi_wstrb = 4'hf;
        wait_cyc = 4'h2;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(8'h00, 32'h0, 2'b00);
        rchk(8'h0c, 32'h7, 2'b00);
        rchk(8'h18, 32'h40, 2'b00);
        rchk(8'h1c, 32'h0, 2'b10);
        $display("test reset values done");
        axw(8'h00, 32'h0000_0068);
        axw(8'h04, 32'h0250_5000);
        axw(8'h0c, 32'h0);
        rchk(8'h0c, 32'h7, 2'b00);
        mask(3'h2);
        src_event <= 16'h0268;
        @(posedge aclk);
        src_event <= 16'h0000;
        offer(8'h44, 3'h5);
        rchk(8'h14, 32'h68, 2'b00);
        ack();
        rchk(8'h14, 32'h60, 2'b00);
        $display("test arbitration done");
        mask(3'h4);
        offer(8'h46, 3'h5);
        ack();
        wait_cyc <= 4'h0;
        nmi_event <= 1'b1;
        @(posedge aclk);
        nmi_event <= 1'b0;
        offer(8'h40, 3'h7);
        ack();
        rchk(8'h0c, 32'h7, 2'b00);
        src_clear <= 16'h0040;
        @(posedge aclk);
        src_clear <= 16'h0000;
        rchk(8'h14, 32'h0, 2'b00);
        src_event <= 16'h0008;
        src_clear <= 16'h0008;
        @(posedge aclk);
        {src_event, src_clear} <= '0;
        rchk(8'h14, 32'h8, 2'b00);
        axw(8'h00, 32'h0);
        rchk(8'h14, 32'h0, 2'b00);
        $display("test mask and nmi done");
        results();
    end
endmodule // tb
`default_nettype wire
